// ===== rtl/otp_mon_pkg.sv
// Package: constants for the OTP status and supply monitor
package otp_mon_pkg;
  // Register indexes on the link read port (no offset is given for either)
  localparam logic [7:0] FACTORY_CONFIG_IDX = 8'h00;
  localparam logic [7:0] STATUS_CHECK_IDX   = 8'h01;
  // Factory shadow array geometry
  localparam int         FACT_REGS    = 8;
  localparam int         FACT_AW      = 3;
  localparam logic [2:0] FACT_LAST    = 3'h7;
  // Lock bits sit in the top bits of the last shadow register
  localparam logic [7:0] LOCK_MASK    = 8'hc0;
  localparam int         LOCK_BIT     = 7;
  // Stored CRC sits in bits [5:3] of the last shadow register
  localparam int         CRC_POS      = 3;
  // CRC polynomial x^3 + x + 1 and seed
  localparam logic [2:0] CRC_POLY     = 3'h3;
  localparam logic [2:0] CRC_SEED     = 3'h7;
  // Field positions in the status register
  localparam int         SC_TEST_POS  = 0;
  localparam int         SC_USER_POS  = 1;
  localparam int         SC_INIT_POS  = 2;
  localparam int         SC_FACT_POS  = 3;
  localparam int         SC_OFF_POS   = 4;
  localparam logic [7:0] SC_RESET     = 8'h1b;
  // Range field of the factory configuration register
  localparam int         RANGE_POS    = 0;
  // Serial number layout: register 0 and 1 low bits hold the serial
  localparam int         SERIAL_W     = 13;
  localparam logic [12:0] SERIAL_FIRST = 13'h0001;
  // Offset monitor counter
  localparam int          OFFCNT_W    = 8;
  localparam logic [7:0]  OFFCNT_MAX  = 8'hff;
  // Capacitor test timing in microseconds, clock 50 MHz
  localparam int CLK_MHZ              = 50;
  localparam int CAP_DELAY_US         = 10;
  localparam int CAP_DURATION_US      = 20;
  localparam int CAP_PERIOD_US        = 1000;
  localparam int CAP_DELAY_CYC        = CAP_DELAY_US * CLK_MHZ;
  localparam int CAP_DURATION_CYC     = CAP_DURATION_US * CLK_MHZ;
  localparam int CAP_PERIOD_CYC       = CAP_PERIOD_US * CLK_MHZ;
  localparam int CAP_CNT_W            = 24;
  // Capacitor test sequencer states
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_OFF  = 2'b10
  } cap_state_t;
endpackage : otp_mon_pkg

// ===== rtl/sync2.sv
// Two-flop synchroniser for one asynchronous level
module sync2
  import otp_mon_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  // First stage is read only by the second
  always_comb
  begin
    meta_nxt = clk_en ? d : meta_r;
    q_nxt    = clk_en ? meta_r : q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : sync2

// ===== rtl/shadow_mem.sv
// Shadow register copy of the factory fuse array, registered read
module shadow_mem
  import otp_mon_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               clk_en,
  input  wire logic               wr_en,
  input  wire logic [FACT_AW-1:0] wr_addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic [FACT_AW-1:0] rd_addr,
  output logic      [7:0]         rd_data
);
  logic [7:0] mem_r [FACT_REGS];
  logic [7:0] rd_nxt;

  always_comb
  begin
    rd_nxt = clk_en ? mem_r[rd_addr] : rd_data;
  end

  // Contents survive reset: fuse load rewrites them
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_en)
    begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= rd_nxt;
    end
  end
endmodule : shadow_mem

// ===== rtl/otp_status_and_supply_monitor.sv
// Top: factory CRC check, status flags, supply and capacitor monitors
// Function
// - CRC x^3+x+1 over factory data, seeded with all ones each pass.
// - CRC check runs only while factory array is locked.
// - CRC recomputed continuously, all factory bits except lock and stored CRC bits.
// - Bits fed LSB first, registers in ascending address order.
// - Mismatch with stored 3-bit CRC clears factory error flag.
// - CRC taken over shadow registers, not fuse cells.
// - Serial and factory config registers covered by CRC only.
// - 13-bit serial from 1 per lot, lot number from 1.
// - Test-mode status bit low in test mode, high otherwise.
// - User OTP mismatch clears user error flag until reset.
// - Factory error flag stays cleared until reset; reads don't restore.
// - Offset init bit set when init done, filter in normal mode.
// - Offset error flag cleared when offset count exceeds limit.
// - Status and config registers read-only over the link.
// - Reset held after power-on until all supplies above threshold.
// - Reset asserted when any supply drops below threshold.
// - VCC dip aborts current response; answer next sync after.
// - After each transmission plus delay, buffer regulator off briefly.
// - Digital and analog regulators periodically off for test interval.
// - Factory config read-only with 3-bit range field.
// - Up/down offset counter; exceeding count limit clears offset flag.
module otp_status_and_supply_monitor
  import otp_mon_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               clk_en,
  input  wire logic               fuse_wr_en,
  input  wire logic [FACT_AW-1:0] fuse_wr_addr,
  input  wire logic [7:0]         fuse_wr_data,
  input  wire logic               test_mode,
  input  wire logic               user_otp_mismatch,
  input  wire logic               offset_init_finished,
  input  wire logic               offset_out_of_limit,
  input  wire logic               offset_monitor_en,
  input  wire logic [OFFCNT_W-1:0] offset_count_limit,
  input  wire logic               vcc_ok_pin,
  input  wire logic               vbuf_ok_pin,
  input  wire logic               vreg_ok_pin,
  input  wire logic               analog_regulator_ok_pin,
  input  wire logic               tx_done,
  input  wire logic               sync_pulse,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_idx,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_rvalid,
  output logic                    tx_abort,
  output logic                    tx_allow,
  output logic                    int_reset_n,
  output logic                    buf_reg_off,
  output logic                    core_reg_off,
  output logic      [7:0]         status_check,
  output logic      [7:0]         factory_config
);
  // Synchronised supply monitor levels
  logic vcc_ok;
  logic vbuf_ok;
  logic vreg_ok;
  logic areg_ok;

  sync2 #(.RST_VAL(1'b0)) u_sync_vcc
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (vcc_ok_pin),
    .q      (vcc_ok)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_vbuf
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (vbuf_ok_pin),
    .q      (vbuf_ok)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_vreg
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (vreg_ok_pin),
    .q      (vreg_ok)
  );
  sync2 #(.RST_VAL(1'b0)) u_sync_areg
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (analog_regulator_ok_pin),
    .q      (areg_ok)
  );

  // Shadow copy scanned by the CRC engine
  logic [FACT_AW-1:0] scan_addr_r;
  logic [FACT_AW-1:0] scan_addr_nxt;
  logic [7:0]         scan_data;

  shadow_mem u_shadow
  (
    .clk     (clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .wr_en   (fuse_wr_en),
    .wr_addr (fuse_wr_addr),
    .wr_data (fuse_wr_data),
    .rd_addr (scan_addr_r),
    .rd_data (scan_data)
  );

  // CRC walk state: address issued, data one cycle later
  logic [FACT_AW-1:0] data_addr_r;
  logic [FACT_AW-1:0] data_addr_nxt;
  logic               data_vld_r;
  logic               data_vld_nxt;
  logic [2:0]         crc_r;
  logic [2:0]         crc_nxt;
  logic [7:0]         cfg_r;
  logic [7:0]         cfg_nxt;
  logic [7:0]         sc_r;
  logic [7:0]         sc_nxt;
  logic [7:0]         feed;
  logic [2:0]         crc_acc;
  logic               crc_fail;

  // Serial crc over one byte, lock bits masked out of the stream
  function automatic logic [2:0] crc_byte(input logic [2:0] c,
                                          input logic [7:0] d,
                                          input logic [7:0] keep);
    logic [2:0] t;
    logic       fb;
    t = c;
    for (int i = 0; i < 8; i++)
    begin
      if (keep[i])
      begin
        fb = t[2] ^ d[i];
        t  = {t[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
      end
    end
    return t;
  endfunction : crc_byte

  // CRC engine and register capture
  always_comb
  begin
    scan_addr_nxt = scan_addr_r + 3'h1;
    data_addr_nxt = scan_addr_r;
    data_vld_nxt  = 1'b1;
    crc_nxt       = crc_r;
    cfg_nxt       = cfg_r;
    crc_fail      = 1'b0;
    crc_acc       = 3'h0;
    // Last register loses lock bits and stored crc from the stream
    feed = (data_addr_r == FACT_LAST) ?
           ~(LOCK_MASK | (8'h07 << CRC_POS)) : 8'hff;
    if (data_vld_r)
    begin
      crc_acc = crc_byte(crc_r, scan_data, feed);
      crc_nxt = crc_acc;
      if (data_addr_r == {FACT_AW{1'b0}})
      begin
        // Fresh seed at start of every pass
        crc_nxt = crc_byte(CRC_SEED, scan_data, feed);
        cfg_nxt = scan_data;
      end
      if (data_addr_r == FACT_LAST)
      begin
        // Compare only when the array is locked
        crc_fail = scan_data[LOCK_BIT] &&
                   (crc_acc != scan_data[CRC_POS +: 3]);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scan_addr_r <= '0;
      data_addr_r <= '0;
      data_vld_r  <= 1'b0;
      crc_r       <= CRC_SEED;
      cfg_r       <= 8'h00;
    end
    else if (clk_en)
    begin
      scan_addr_r <= scan_addr_nxt;
      data_addr_r <= data_addr_nxt;
      data_vld_r  <= data_vld_nxt;
      crc_r       <= crc_nxt;
      cfg_r       <= cfg_nxt;
    end
  end

  // Offset monitor up/down counter, rails at both ends
  logic [OFFCNT_W-1:0] offcnt_r;
  logic [OFFCNT_W-1:0] offcnt_nxt;

  always_comb
  begin
    offcnt_nxt = offcnt_r;
    if (offset_monitor_en)
    begin
      if (offset_out_of_limit && offcnt_r != OFFCNT_MAX)
        offcnt_nxt = offcnt_r + 8'h01;
      else if (!offset_out_of_limit && offcnt_r != 8'h00)
        offcnt_nxt = offcnt_r - 8'h01;
    end
  end

  // Status flags: active-low faults are sticky until reset
  always_comb
  begin
    sc_nxt = sc_r;
    sc_nxt[SC_TEST_POS] = ~test_mode;
    if (user_otp_mismatch)
      sc_nxt[SC_USER_POS] = 1'b0;
    if (offset_init_finished)
      sc_nxt[SC_INIT_POS] = 1'b1;
    if (crc_fail)
      sc_nxt[SC_FACT_POS] = 1'b0;
    if (offcnt_r > offset_count_limit)
      sc_nxt[SC_OFF_POS] = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sc_r     <= SC_RESET;
      offcnt_r <= '0;
    end
    else if (clk_en)
    begin
      sc_r     <= sc_nxt;
      offcnt_r <= offcnt_nxt;
    end
  end

  // Read-only link port: no write path exists at all
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;

  always_comb
  begin
    rvalid_nxt = reg_rd;
    rdata_nxt  = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_idx)
        FACTORY_CONFIG_IDX: rdata_nxt = cfg_r;
        STATUS_CHECK_IDX:   rdata_nxt = sc_r;
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  // Supply supervision and capacitor test sequencer
  cap_state_t           cap_st_r;
  cap_state_t           cap_st_nxt;
  logic [CAP_CNT_W-1:0] cap_cnt_r;
  logic [CAP_CNT_W-1:0] cap_cnt_nxt;
  logic [CAP_CNT_W-1:0] per_cnt_r;
  logic [CAP_CNT_W-1:0] per_cnt_nxt;
  logic                 core_off_nxt;
  logic                 rst_nxt;
  logic                 allow_nxt;
  logic                 abort_nxt;
  logic                 vcc_ok_d_r;

  always_comb
  begin
    // All supplies must be good; reset follows any drop
    rst_nxt     = vcc_ok & vbuf_ok & vreg_ok & areg_ok;
    abort_nxt   = vcc_ok_d_r & ~vcc_ok & ~tx_abort;
    allow_nxt   = tx_allow;
    if (!vcc_ok)
      allow_nxt = 1'b0;
    else if (sync_pulse)
      allow_nxt = 1'b1;
    cap_st_nxt  = cap_st_r;
    cap_cnt_nxt = cap_cnt_r;
    unique case (cap_st_r)
      CAP_IDLE:
        if (tx_done)
        begin
          cap_st_nxt  = CAP_WAIT;
          cap_cnt_nxt = CAP_CNT_W'(CAP_DELAY_CYC - 1);
        end
      CAP_WAIT:
        if (cap_cnt_r == '0)
        begin
          cap_st_nxt  = CAP_OFF;
          cap_cnt_nxt = CAP_CNT_W'(CAP_DURATION_CYC - 1);
        end
        else
          cap_cnt_nxt = cap_cnt_r - 1'b1;
      CAP_OFF:
        if (cap_cnt_r == '0)
          cap_st_nxt = CAP_IDLE;
        else
          cap_cnt_nxt = cap_cnt_r - 1'b1;
      default:
        cap_st_nxt = CAP_IDLE;
    endcase
    // Window keyed to the present count: first period after reset is full
    per_cnt_nxt = (per_cnt_r == CAP_CNT_W'(CAP_PERIOD_CYC - 1)) ?
                  '0 : per_cnt_r + 1'b1;
    core_off_nxt = per_cnt_r < CAP_CNT_W'(CAP_DURATION_CYC);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_st_r     <= CAP_IDLE;
      cap_cnt_r    <= '0;
      per_cnt_r    <= '0;
      core_reg_off <= 1'b0;
      buf_reg_off  <= 1'b0;
      int_reset_n  <= 1'b0;
      tx_allow     <= 1'b0;
      tx_abort     <= 1'b0;
      vcc_ok_d_r   <= 1'b0;
      reg_rdata    <= 8'h00;
      reg_rvalid   <= 1'b0;
      status_check <= SC_RESET;
      factory_config <= 8'h00;
    end
    else if (clk_en)
    begin
      cap_st_r     <= cap_st_nxt;
      cap_cnt_r    <= cap_cnt_nxt;
      per_cnt_r    <= per_cnt_nxt;
      core_reg_off <= core_off_nxt;
      buf_reg_off  <= (cap_st_nxt == CAP_OFF);
      int_reset_n  <= rst_nxt;
      tx_allow     <= allow_nxt;
      tx_abort     <= abort_nxt;
      vcc_ok_d_r   <= vcc_ok;
      reg_rdata    <= rdata_nxt;
      reg_rvalid   <= rvalid_nxt;
      status_check <= sc_nxt;
      factory_config <= cfg_nxt;
    end
  end
endmodule : otp_status_and_supply_monitor

// ===== tb/otp_mon_assertions.sv
// Checker: port properties of the OTP status and supply monitor
module otp_mon_checker
  import otp_mon_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       clk_en,
  input wire logic       test_mode,
  input wire logic       offset_init_finished,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_idx,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       tx_abort,
  input wire logic       tx_allow,
  input wire logic       buf_reg_off,
  input wire logic       core_reg_off,
  input wire logic [7:0] status_check
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [23:0] buf_cnt_r, buf_cnt_nxt, gap_r, gap_nxt;
  logic        core_r, seen_r, seen_nxt;
  // Off-time and period counts; a rise restarts the gap
  always_comb
  begin
    buf_cnt_nxt = buf_reg_off ? buf_cnt_r + 24'h1 : 24'h0;
    gap_nxt = (core_reg_off && !core_r) ? 24'h1 : gap_r + 24'h1;
    seen_nxt = seen_r | (core_reg_off & ~core_r);
  end
  // Registers only
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      buf_cnt_r <= 24'h0;
      gap_r <= 24'h0;
      core_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      buf_cnt_r <= buf_cnt_nxt;
      gap_r <= gap_nxt;
      core_r <= core_reg_off;
      seen_r <= seen_nxt;
    end
  rd_answer_a: assert property (reg_rd && clk_en |=> reg_rvalid)
    else $error("read not answered");
  rd_unmapped_a: assert property (reg_rd && clk_en &&
    reg_idx > STATUS_CHECK_IDX |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_status_a: assert property (reg_rd && clk_en &&
    reg_idx == STATUS_CHECK_IDX |=> reg_rdata == $past(status_check))
    else $error("status read wrong");
  test_flag_a: assert property (test_mode |->
    ##[1:4] !status_check[SC_TEST_POS])
    else $error("test flag not low");
  fact_sticky_a: assert property ($fell(status_check[SC_FACT_POS]) |->
    !status_check[SC_FACT_POS] [*8])
    else $error("factory flag restored");
  init_flag_a: assert property (offset_init_finished |->
    ##[1:4] status_check[SC_INIT_POS])
    else $error("init flag not set");
  abort_pulse_a: assert property (tx_abort |=> !tx_abort && !tx_allow)
    else $error("abort pulse wrong");
  buf_len_a: assert property ($fell(buf_reg_off) |->
    buf_cnt_r == CAP_DURATION_CYC)
    else $error("buffer off time wrong");
  core_gap_a: assert property ($rose(core_reg_off) && seen_r |->
    gap_r == CAP_PERIOD_CYC)
    else $error("core test period wrong");
  cover property ($fell(status_check[SC_FACT_POS]));
  cover property ($rose(buf_reg_off));
  cover property (tx_abort);
endmodule : otp_mon_checker

bind otp_status_and_supply_monitor otp_mon_checker chk (.*);

// ===== tb/psi5_master_model.sv
// PSI5 master stand-in: register reads and sync pulses
module psi5_master_model
(
  input  wire logic       clk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_rd,
  output logic [7:0]      reg_idx,
  output logic            sync_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_rd = 1'b0;
    reg_idx = 8'h00;
    sync_pulse = 1'b0;
  end
  // Read only: the link has no write, idle index is scrambled
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk) #1;
    reg_rd = 1'b1;
    reg_idx = idx;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_idx = ~idx;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
  // One-cycle sync pulse
  task automatic sync();
    @(posedge clk) #1;
    sync_pulse = 1'b1;
    @(posedge clk) #1;
    sync_pulse = 1'b0;
  endtask : sync
endmodule : psi5_master_model

// ===== tb/test_otp_status_and_supply_monitor.sv
// Bench: random and corner tests of the OTP status and supply monitor
module test_otp_status_and_supply_monitor
  import otp_mon_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, clk_en, fuse_wr_en, test_mode, tx_done, cap_missing;
  logic user_otp_mismatch, offset_init_finished, offset_out_of_limit;
  logic offset_monitor_en, vcc_ok_pin, vbuf_ok_pin, vreg_ok_pin;
  logic analog_regulator_ok_pin, sync_pulse, reg_rd, reg_rvalid;
  logic tx_abort, tx_allow, int_reset_n, buf_reg_off, core_reg_off;
  logic [2:0] fuse_wr_addr;
  logic [7:0] fuse_wr_data, offset_count_limit, reg_idx, reg_rdata, d;
  logic [7:0] status_check, factory_config;
  logic [7:0] mem [8];
  logic [3:0] ok_v;
  int         failures, checks, tmo, n, lim, b;
  assign vcc_ok_pin = ok_v[0];
  // Missing buffer capacitor: rail collapses while the regulator is off
  assign vbuf_ok_pin = ok_v[1] & ~(cap_missing & buf_reg_off);
  assign vreg_ok_pin = ok_v[2];
  assign analog_regulator_ok_pin = ok_v[3];
  // 50 MHz clock
  always #10 clk = ~clk;
  otp_status_and_supply_monitor dut (.clk, .arst_n, .clk_en, .fuse_wr_en,
    .fuse_wr_addr, .fuse_wr_data, .test_mode, .user_otp_mismatch,
    .offset_init_finished, .offset_out_of_limit, .offset_monitor_en,
    .offset_count_limit, .vcc_ok_pin, .vbuf_ok_pin, .vreg_ok_pin,
    .analog_regulator_ok_pin, .tx_done, .sync_pulse, .reg_rd, .reg_idx,
    .reg_rdata, .reg_rvalid, .tx_abort, .tx_allow, .int_reset_n,
    .buf_reg_off, .core_reg_off, .status_check, .factory_config);
  psi5_master_model master (.clk, .reg_rvalid, .reg_rdata, .reg_rd,
    .reg_idx, .sync_pulse);
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Expected CRC: seed all ones, LSB first, lock and stored CRC skipped
  function automatic logic [2:0] crc_of(input logic [7:0] m [8]);
    logic [2:0] c;
    logic       fb;
    c = 3'h7;
    for (int a = 0; a < 8; a++)
      for (int k = 0; k < 8; k++)
        if (a < 7 || k < 3)
        begin
          fb = c[2] ^ m[a][k];
          c = {c[1:0], 1'b0} ^ (fb ? 3'h3 : 3'h0);
        end
    return c;
  endfunction : crc_of
  function automatic logic [7:0] sc_of(input logic t, u, i, f, o);
    logic [7:0] s;
    s = 8'h00;
    s[SC_TEST_POS] = t;
    s[SC_USER_POS] = u;
    s[SC_INIT_POS] = i;
    s[SC_FACT_POS] = f;
    s[SC_OFF_POS] = o;
    return s;
  endfunction : sc_of
  // Fuse load in address order, then time for several scans
  task automatic load();
    for (int a = 0; a < 8; a++)
    begin
      fuse_wr_en = 1'b1;
      fuse_wr_addr = a[2:0];
      fuse_wr_data = mem[a];
      cyc(1);
    end
    fuse_wr_en = 1'b0;
    cyc(30);
  endtask : load
  // Hang guard, about 51k cycles expected
  always @(posedge clk)
  begin
    tmo++;
    if (tmo == 60000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    {clk, arst_n, fuse_wr_en, test_mode, tx_done, cap_missing} = '0;
    {user_otp_mismatch, offset_init_finished, offset_out_of_limit} = '0;
    {fuse_wr_addr, fuse_wr_data, offset_count_limit, ok_v} = '0;
    clk_en = 1'b1;
    offset_monitor_en = 1'b1;
    n = $urandom(32'h423a);
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    cyc(3);
    cmp(status_check, sc_of(1, 1, 0, 1, 1));
    // Reset holds until the last supply is good
    for (int i = 0; i < 4; i++)
    begin
      ok_v[i] = 1'b1;
      cyc(5);
      cmp_bit(int_reset_n, i == 3);
    end
    $display("power-up test done");
    // Random array: unlocked bad CRC, locked good, corrupted, mended
    for (int a = 0; a < 8; a++)
      mem[a] = 8'($urandom);
    mem[7][7:6] = 2'b00;
    mem[7][5:3] = ~crc_of(mem);
    load();
    cmp_bit(status_check[SC_FACT_POS], 1'b1);
    mem[7][7:6] = 2'b11;
    mem[7][5:3] = crc_of(mem);
    load();
    cmp_bit(status_check[SC_FACT_POS], 1'b1);
    cmp(factory_config, mem[0]);
    master.rd(FACTORY_CONFIG_IDX, d);
    cmp(d, mem[0]);
    master.rd(8'(2 + $urandom_range(253)), d);
    cmp(d, 8'h00);
    b = $urandom_range(7);
    mem[0][b] = ~mem[0][b];
    load();
    cmp_bit(status_check[SC_FACT_POS], 1'b0);
    mem[0][b] = ~mem[0][b];
    load();
    master.rd(STATUS_CHECK_IDX, d);
    cmp_bit(d[SC_FACT_POS], 1'b0);
    $display("crc test done");
    // Test mode follows; faults latch
    test_mode = 1'b1;
    cyc(4);
    cmp_bit(status_check[SC_TEST_POS], 1'b0);
    test_mode = 1'b0;
    cyc(4);
    cmp_bit(status_check[SC_TEST_POS], 1'b1);
    // Frozen clock enable holds the user flag
    clk_en = 1'b0;
    user_otp_mismatch = 1'b1;
    cyc(3);
    cmp_bit(status_check[SC_USER_POS], 1'b1);
    clk_en = 1'b1;
    user_otp_mismatch = 1'b1;
    cyc(1);
    user_otp_mismatch = 1'b0;
    cyc(12);
    cmp_bit(status_check[SC_USER_POS], 1'b0);
    offset_init_finished = 1'b1;
    cyc(4);
    cmp_bit(status_check[SC_INIT_POS], 1'b1);
    // Count equal to the limit keeps the flag, above it clears
    lim = 4 + $urandom_range(11);
    offset_count_limit = 8'(lim);
    // Disabled monitor must not count
    offset_monitor_en = 1'b0;
    offset_out_of_limit = 1'b1;
    cyc(lim + 4);
    cmp_bit(status_check[SC_OFF_POS], 1'b1);
    offset_monitor_en = 1'b1;
    offset_out_of_limit = 1'b1;
    cyc(lim);
    offset_out_of_limit = 1'b0;
    cyc(4);
    cmp_bit(status_check[SC_OFF_POS], 1'b1);
    cyc(lim);
    offset_out_of_limit = 1'b1;
    cyc(lim + 4);
    cmp(status_check, sc_of(1, 0, 1, 0, 0));
    offset_init_finished = 1'b0;
    offset_out_of_limit = 1'b0;
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(6);
    cmp(status_check, sc_of(1, 1, 0, 1, 1));
    $display("status test done");
    // Each supply alone forces internal reset
    for (int i = 0; i < 4; i++)
    begin
      ok_v[i] = 1'b0;
      cyc(5);
      cmp_bit(int_reset_n, 1'b0);
      ok_v[i] = 1'b1;
      cyc(5);
      cmp_bit(int_reset_n, 1'b1);
    end
    // Micro-cut: abort, silent until the next sync
    ok_v[0] = 1'b0;
    for (n = 0; n < 6 && tx_abort !== 1'b1; n++)
      cyc(1);
    cmp_bit(tx_abort, 1'b1);
    ok_v[0] = 1'b1;
    cyc(8);
    cmp_bit(tx_allow, 1'b0);
    master.sync();
    cyc(1);
    cmp_bit(tx_allow, 1'b1);
    $display("supply test done");
    // Buffer test after a frame, capacitor missing
    cap_missing = 1'b1;
    tx_done = 1'b1;
    cyc(1);
    tx_done = 1'b0;
    for (n = 1; n < CAP_DELAY_CYC + 5 && buf_reg_off !== 1'b1; n++)
      cyc(1);
    cmp_bit(n >= CAP_DELAY_CYC && n <= CAP_DELAY_CYC + 2, 1'b1);
    cyc(10);
    cmp_bit(int_reset_n, 1'b0);
    for (n = 0; n < CAP_DURATION_CYC + 5 && buf_reg_off === 1'b1; n++)
      cyc(1);
    cap_missing = 1'b0;
    // Next periodic core window and its length
    for (n = 0; n < CAP_PERIOD_CYC && core_reg_off !== 1'b1; n++)
      cyc(1);
    for (n = 0; n < CAP_DURATION_CYC + 5 && core_reg_off === 1'b1; n++)
      cyc(1);
    cmp_bit(n >= CAP_DURATION_CYC - 1 && n <= CAP_DURATION_CYC + 1, 1'b1);
    $display("regulator test done");
    close_out();
  end
endmodule : test_otp_status_and_supply_monitor
